// >>> logic/ppr_pkg.sv
/*
 Package for the playback and readout data path of one processing node.
 Holds register offsets, field positions, reset values, sizes and timing counts.
 Assumes core_clk runs at CLK_MHZ, 100 MHz, not at the bunch-crossing clock of the node.
*/
`default_nettype none

package ppr_pkg;

    // Clocking and timing.
    localparam int CLK_MHZ = 100;
    localparam int BC_CLK_KHZ = 40080;
    localparam int RETAIN_NS = 3000;
    localparam int RETAIN_CYC = (RETAIN_NS * CLK_MHZ) / 1000;

    // Sizes.
    localparam int PB_DEPTH = 256;
    localparam int PB_AW = 8;
    localparam int RO_DEPTH = 512;
    localparam int RO_AW = 9;
    localparam int FIFO_DEPTH = 8;
    localparam int LINK_PAIRS = 48;
    localparam int CAND_N = 4;
    localparam int CAND_W = 12;
    localparam int CAND_PRESENT = 11;
    localparam int CAND_TAU = 10;
    localparam int REC_W = 16;
    localparam int REC_SLOTS = 3;
    localparam int FIFO_W = LINK_PAIRS + 1;

    // Register offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DEPTH = 8'h04;
    localparam logic [7:0] OFS_WIN = 8'h08;
    localparam logic [7:0] OFS_LD_ADDR = 8'h0c;
    localparam logic [7:0] OFS_PB_IN_LO = 8'h10;
    localparam logic [7:0] OFS_PB_IN_HI = 8'h14;
    localparam logic [7:0] OFS_PB_OUT_LO = 8'h18;
    localparam logic [7:0] OFS_PB_OUT_HI = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_CUT_CNT = 8'h24;
    localparam logic [7:0] OFS_MISS_CNT = 8'h28;

    // Control register fields.
    localparam int CTRL_PB_BIT = 0;
    localparam int CTRL_OPB_BIT = 1;
    localparam int CTRL_RO_LSB = 2;

    // Reset values.
    localparam logic [1:0] RO_EN_RST = 2'h3;
    localparam logic [8:0] DEPTH_RST = 9'(RETAIN_CYC);
    localparam logic [8:0] WIN_RST = 9'h004;

    // Readout copy states.
    typedef enum logic [1:0] {
        CP_IDLE = 2'b01,
        CP_COPY = 2'b10
    } ppr_cp_t;

endpackage

`default_nettype wire

// >>> logic/ppr_top.sv
/*
 Playback, trigger object record and readout data path of one processing node,
 with its readout FIFO. Assumes live data, link ready and the register port are
 on core_clk; the trigger accept arrives from the backplane and is synchronised.
*/
// Function
// - In playback, live input is ignored and playback memory words are used.
// - Input-memory playback words enter only at the feature-extraction input stage.
// - Output playback drives the real-time output from a second memory set.
// - Playback always uses input memories; output memories are a separate option.
// - One playback switch covers all input channels together.
// - Software selects playback and loads memories through the register port.
// - Each playback memory holds 256 words, addressed sequentially.
// - One record is made for each of the first three jet or tau objects found.
// - Records are ranked; excess beyond the link capacity is dropped.
// - Records leave on 48 output pairs each core_clk cycle.
// - Input and records are kept in readout memory, retention up to 3 us.
// - Each trigger accept copies a programmable window into the readout FIFO; an accept during a running copy is only counted.
// - Only categories enabled for readout are copied.
// - The readout FIFO drains over one serial transceiver link.
// - A local register interface gives access to registers and writes the playback memories; readout memory has no register access.
// - The data path runs on core_clk, taken as 100 MHz for the retention count, not on the 40.08 MHz bunch-crossing clock.
`timescale 1ns/1ns
`default_nettype none

module ppr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } ppr_fifo_st_t;

    ppr_fifo_st_t s_r;
    ppr_fifo_st_t s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    always_comb
    begin
        s_nxt = s_r;
        in_ready = (s_r.cnt != (AW+1)'(DEPTH));
        push = in_valid && in_ready;
        pop = (s_r.cnt != '0) && (!s_r.ov || out_ready);
        if (pop)
        begin
            s_nxt.od = mem[s_r.rp];
            s_nxt.ov = 1'b1;
            s_nxt.rp = s_r.rp + 1'b1;
        end
        else if (out_ready)
        begin
            s_nxt.ov = 1'b0;
        end
        if (push)
        begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[s_r.wp] <= in_data;
        end
    end

    assign out_valid = s_r.ov;
    assign out_data = s_r.od;

    link_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("Stalled link word changed or vanished.");
endmodule

module ppr_top (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Real-time path.
    input wire logic [ppr_pkg::LINK_PAIRS-1:0] live_data,
    output logic [ppr_pkg::LINK_PAIRS-1:0] rt_out,
    // Readout path.
    input wire logic trigger_accept,
    output logic link_valid,
    input wire logic link_ready,
    output logic [ppr_pkg::FIFO_W-1:0] link_data
);
    localparam int W = ppr_pkg::LINK_PAIRS;

    typedef struct packed {
        logic pb_en;
        logic out_pb_en;
        logic [1:0] ro_en;
        logic [8:0] depth;
        logic [8:0] win;
        logic [ppr_pkg::PB_AW-1:0] ld_addr;
        logic [31:0] ld_lo;
        logic [ppr_pkg::PB_AW-1:0] pb_ptr;
        logic [ppr_pkg::RO_AW-1:0] ro_wptr;
        logic [ppr_pkg::RO_AW-1:0] cp_ptr;
        logic [8:0] cp_left;
        logic cp_cat;
        ppr_pkg::ppr_cp_t st;
        logic [W-1:0] feat_in;
        logic [W-1:0] rt_out;
        logic [15:0] cut_cnt;
        logic [15:0] miss_cnt;
        logic [31:0] rdata;
        logic [2:0] acc_sync;
    } ppr_st_t;

    ppr_st_t s_r;
    ppr_st_t s_nxt;
    logic [W-1:0] in_mem [ppr_pkg::PB_DEPTH];
    logic [W-1:0] out_mem [ppr_pkg::PB_DEPTH];
    logic [2*W-1:0] ro_mem [ppr_pkg::RO_DEPTH];
    logic [W-1:0] pb_word;
    logic [W-1:0] out_word;
    logic [W-1:0] rec_pack;
    logic cut;
    logic in_we;
    logic out_we;
    logic accept;
    logic fifo_valid;
    logic fifo_ready;
    logic [ppr_pkg::FIFO_W-1:0] fifo_data;
    logic [2*W-1:0] ro_word;

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs, input logic st);
        reg_hit = st && (a == ofs);
    endfunction

    always_comb
    begin
        int n;
        logic [ppr_pkg::CAND_W-1:0] c;
        n = 0;
        c = '0;
        s_nxt = s_r;
        pb_word = in_mem[s_r.pb_ptr];
        out_word = out_mem[s_r.pb_ptr];
        ro_word = ro_mem[s_r.cp_ptr];
        rec_pack = '0;
        cut = 1'b0;
        in_we = reg_hit(reg_addr, ppr_pkg::OFS_PB_IN_HI, reg_wr);
        out_we = reg_hit(reg_addr, ppr_pkg::OFS_PB_OUT_HI, reg_wr);
        s_nxt.acc_sync = {s_r.acc_sync[1:0], trigger_accept};
        accept = s_r.acc_sync[1] && !s_r.acc_sync[2];

        s_nxt.pb_ptr = s_r.pb_en ? s_r.pb_ptr + 1'b1 : '0;
        s_nxt.feat_in = s_r.pb_en ? pb_word : live_data;

        for (int i = 0; i < ppr_pkg::CAND_N; i++)
        begin
            c = s_r.feat_in[i*ppr_pkg::CAND_W +: ppr_pkg::CAND_W];
            if (c[ppr_pkg::CAND_PRESENT])
            begin
                if (n < ppr_pkg::REC_SLOTS)
                begin
                    rec_pack[n*ppr_pkg::REC_W +: ppr_pkg::REC_W] =
                        {1'b1, c[ppr_pkg::CAND_TAU], 2'(i), c[9:0], 2'h0};
                end
                else
                begin
                    cut = 1'b1;
                end
                n = n + 1;
            end
        end
        if (cut)
        begin
            s_nxt.cut_cnt = s_r.cut_cnt + 16'h0001;
        end

        s_nxt.rt_out = (s_r.pb_en && s_r.out_pb_en) ? out_word : rec_pack;

        s_nxt.ro_wptr = s_r.ro_wptr + 1'b1;

        unique case (s_r.st)
            ppr_pkg::CP_IDLE:
            begin
                if (accept && s_r.ro_en != 2'h0 && s_r.win != 9'h000)
                begin
                    s_nxt.st = ppr_pkg::CP_COPY;
                    s_nxt.cp_ptr = s_r.ro_wptr - s_r.depth;
                    s_nxt.cp_left = (s_r.win > s_r.depth) ? s_r.depth : s_r.win;
                    s_nxt.cp_cat = !s_r.ro_en[0];
                end
            end
            ppr_pkg::CP_COPY:
            begin
                if (accept)
                begin
                    s_nxt.miss_cnt = s_r.miss_cnt + 16'h0001;
                end
                if (fifo_ready)
                begin
                    if (!s_r.cp_cat && s_r.ro_en[1])
                    begin
                        s_nxt.cp_cat = 1'b1;
                    end
                    else
                    begin
                        s_nxt.cp_cat = !s_r.ro_en[0];
                        s_nxt.cp_ptr = s_r.cp_ptr + 1'b1;
                        s_nxt.cp_left = s_r.cp_left - 9'h001;
                        if (s_r.cp_left == 9'h001)
                        begin
                            s_nxt.st = ppr_pkg::CP_IDLE;
                        end
                    end
                end
            end
        endcase
        fifo_valid = (s_r.st == ppr_pkg::CP_COPY);
        fifo_data = {s_r.cp_cat, s_r.cp_cat ? ro_word[W-1:0] : ro_word[2*W-1:W]};

        if (reg_hit(reg_addr, ppr_pkg::OFS_CTRL, reg_wr))
        begin
            s_nxt.pb_en = reg_wdata[ppr_pkg::CTRL_PB_BIT];
            s_nxt.out_pb_en = reg_wdata[ppr_pkg::CTRL_OPB_BIT];
            s_nxt.ro_en = reg_wdata[ppr_pkg::CTRL_RO_LSB +: 2];
        end
        if (reg_hit(reg_addr, ppr_pkg::OFS_DEPTH, reg_wr))
        begin
            s_nxt.depth = (reg_wdata > 32'(ppr_pkg::RETAIN_CYC)) ?
                ppr_pkg::DEPTH_RST : reg_wdata[8:0];
        end
        if (reg_hit(reg_addr, ppr_pkg::OFS_WIN, reg_wr))
        begin
            s_nxt.win = reg_wdata[8:0];
        end
        if (reg_hit(reg_addr, ppr_pkg::OFS_LD_ADDR, reg_wr))
        begin
            s_nxt.ld_addr = reg_wdata[ppr_pkg::PB_AW-1:0];
        end
        if (reg_hit(reg_addr, ppr_pkg::OFS_PB_IN_LO, reg_wr) ||
            reg_hit(reg_addr, ppr_pkg::OFS_PB_OUT_LO, reg_wr))
        begin
            s_nxt.ld_lo = reg_wdata;
        end
        if (in_we || out_we)
        begin
            s_nxt.ld_addr = s_r.ld_addr + 1'b1;
        end
        s_nxt.rdata = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                ppr_pkg::OFS_CTRL: s_nxt.rdata = {28'h0, s_r.ro_en, s_r.out_pb_en, s_r.pb_en};
                ppr_pkg::OFS_DEPTH: s_nxt.rdata = {23'h0, s_r.depth};
                ppr_pkg::OFS_WIN: s_nxt.rdata = {23'h0, s_r.win};
                ppr_pkg::OFS_LD_ADDR: s_nxt.rdata = {24'h0, s_r.ld_addr};
                ppr_pkg::OFS_STATUS:
                    s_nxt.rdata = {23'h0, s_r.pb_ptr, s_r.st == ppr_pkg::CP_COPY};
                ppr_pkg::OFS_CUT_CNT: s_nxt.rdata = {16'h0, s_r.cut_cnt};
                ppr_pkg::OFS_MISS_CNT: s_nxt.rdata = {16'h0, s_r.miss_cnt};
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r <= '0;
            s_r.ro_en <= ppr_pkg::RO_EN_RST;
            s_r.depth <= ppr_pkg::DEPTH_RST;
            s_r.win <= ppr_pkg::WIN_RST;
            s_r.st <= ppr_pkg::CP_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge core_clk)
    begin
        ro_mem[s_r.ro_wptr] <= {s_r.feat_in, rec_pack};
        if (in_we)
        begin
            in_mem[s_r.ld_addr] <= {reg_wdata[15:0], s_r.ld_lo};
        end
        if (out_we)
        begin
            out_mem[s_r.ld_addr] <= {reg_wdata[15:0], s_r.ld_lo};
        end
    end

    ppr_fifo #(
        .WIDTH(ppr_pkg::FIFO_W),
        .DEPTH(ppr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(fifo_valid),
        .in_ready(fifo_ready),
        .in_data(fifo_data),
        .out_valid(link_valid),
        .out_ready(link_ready),
        .out_data(link_data)
    );

    assign reg_rdata = s_r.rdata;
    assign rt_out = s_r.rt_out;

    pb_replace_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_r.pb_en |=> s_r.feat_in == $past(pb_word))
        else $error("Playback word not used at feature input.");
    live_pass_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !s_r.pb_en |=> s_r.feat_in == $past(live_data))
        else $error("Live data not passed to feature input.");
    out_pb_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_r.pb_en && s_r.out_pb_en |=> rt_out == $past(out_word))
        else $error("Output playback word not driven.");
    out_alg_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(s_r.pb_en && s_r.out_pb_en) |=> rt_out == $past(rec_pack))
        else $error("Algorithm result not driven.");
    ptr_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_r.pb_en ##1 s_r.pb_en |-> s_r.pb_ptr == 8'($past(s_r.pb_ptr) + 8'h01))
        else $error("Playback pointer did not step by one.");
    cut_count_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cut |=> s_r.cut_cnt == 16'($past(s_r.cut_cnt) + 16'h0001))
        else $error("Excess record not counted.");
    load_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        in_we |=> s_r.ld_addr == 8'($past(s_r.ld_addr) + 8'h01))
        else $error("Load address did not advance.");
    copy_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_r.st == ppr_pkg::CP_IDLE && accept && s_r.ro_en != 2'h0 && s_r.win != 9'h000
        |=> s_r.st == ppr_pkg::CP_COPY)
        else $error("Trigger accept did not start a copy.");
    cat_enabled_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        fifo_valid && fifo_ready |-> s_r.ro_en[fifo_data[W]])
        else $error("Disabled category pushed to readout.");
endmodule

`default_nettype wire

// >>> test/ppr_sink_model.sv
/*
 Readout link sink model standing in for the aggregating device.
 Assumes link_valid and link_data come from ppr_top on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module ppr_sink_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Readout link.
    input wire logic link_valid,
    output logic link_ready,
    input wire logic [ppr_pkg::FIFO_W-1:0] link_data,
    // Bench control and counts.
    input wire logic stall,
    output logic [15:0] word_cnt,
    output logic [15:0] rec_cnt,
    output logic [15:0] hold_errs
);
    logic was_stalled;
    logic [ppr_pkg::FIFO_W-1:0] last_data;

    assign link_ready = !stall;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            word_cnt <= 16'h0000;
            rec_cnt <= 16'h0000;
            hold_errs <= 16'h0000;
            was_stalled <= 1'b0;
            last_data <= '0;
        end
        else
        begin
            if (link_valid && link_ready)
            begin
                word_cnt <= word_cnt + 16'h0001;
                rec_cnt <= rec_cnt + 16'(link_data[ppr_pkg::FIFO_W-1]);
            end
            if (was_stalled && (!link_valid || link_data !== last_data))
                hold_errs <= hold_errs + 16'h0001;
            was_stalled <= link_valid && !link_ready;
            last_data <= link_data;
        end
    end
endmodule

`default_nettype wire

// >>> test/ppr_top_tb.sv
/*
 Self-checking testbench for ppr_top: registers, ranking, playback, readout.
 Assumes ppr_pkg is compiled first and the sink model stands on the link.
*/
`timescale 1ns/1ns
`default_nettype none

module ppr_top_tb;
    localparam logic [47:0] LIVE_A = {12'h804, 12'h803, 12'hc02, 12'h801};
    localparam logic [47:0] LIVE_B = {12'hc10, 12'h000, 12'h8ff, 12'h000};
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [ppr_pkg::LINK_PAIRS-1:0] live_data = '0;
    logic [ppr_pkg::LINK_PAIRS-1:0] rt_out;
    logic trigger_accept = 1'b0;
    logic link_valid;
    logic link_ready;
    logic [ppr_pkg::FIFO_W-1:0] link_data;
    logic stall = 1'b0;
    logic [15:0] word_cnt;
    logic [15:0] rec_cnt;
    logic [15:0] hold_errs;
    int mismatches = 0;
    int check_count = 0;
    int n;

    ppr_top uut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .live_data(live_data), .rt_out(rt_out), .trigger_accept(trigger_accept),
        .link_valid(link_valid), .link_ready(link_ready), .link_data(link_data));

    ppr_sink_model sink (.core_clk(core_clk), .reset_n(reset_n), .link_valid(link_valid),
        .link_ready(link_ready), .link_data(link_data), .stall(stall),
        .word_cnt(word_cnt), .rec_cnt(rec_cnt), .hold_errs(hold_errs));

    function automatic logic [15:0] rec(input logic [1:0] pos, input logic [11:0] c);
        return {1'b1, c[10], pos, c[9:0], 2'b00};
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check({16'h0, reg_rdata}, {16'h0, e}, m);
    endtask

    task automatic accept();
        @(posedge core_clk);
        trigger_accept <= 1'b1;
        repeat (2) @(posedge core_clk);
        trigger_accept <= 1'b0;
    endtask

    task automatic wait_words(input logic [15:0] target);
        n = 0;
        while (word_cnt !== target && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (20) @(posedge core_clk);
        #1;
        if (n >= 400)
        begin
            mismatches++;
            $display("wrong value at %0t: link words never arrived", $time);
            give_verdict();
        end
    endtask

    task automatic pb_watch(input logic out_mode, input logic [7:0] first);
        logic [7:0] p;
        repeat (4) @(posedge core_clk);
        #1;
        p = first;
        repeat (300)
        begin
            @(posedge core_clk);
            #1;
            p = p + 8'h01;
            if (out_mode)
                check(rt_out, {8'hc3, 32'h0, p}, "output playback");
            else
                check(rt_out, {32'h0, 4'h8, 2'b00, p, 2'b00}, "input playback");
        end
    endtask

    initial forever #5 core_clk = ~core_clk;

    initial
    begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk(ppr_pkg::OFS_CTRL, 32'h0000000c, "ctrl reset");
        rd_chk(ppr_pkg::OFS_DEPTH, 32'h0000012c, "depth reset");
        rd_chk(ppr_pkg::OFS_WIN, 32'h00000004, "window reset");
        wr(8'hfc, 32'hffffffff);
        rd_chk(8'hfc, 32'h0, "unmapped");
        wr(ppr_pkg::OFS_DEPTH, 32'h00000010);
        rd_chk(ppr_pkg::OFS_DEPTH, 32'h00000010, "depth write");
        wr(ppr_pkg::OFS_DEPTH, 32'h000001f4);
        rd_chk(ppr_pkg::OFS_DEPTH, 32'h0000012c, "depth limit");
        $display("test registers done");
        @(posedge core_clk);
        live_data <= LIVE_A;
        repeat (3) @(posedge core_clk);
        #1 check(rt_out, {rec(2'h2, 12'h803), rec(2'h1, 12'hc02), rec(2'h0, 12'h801)}, "rank");
        @(posedge core_clk);
        live_data <= LIVE_B;
        repeat (3) @(posedge core_clk);
        #1 check(rt_out, {16'h0, rec(2'h3, 12'hc10), rec(2'h1, 12'h8ff)}, "sparse");
        @(posedge core_clk);
        live_data <= '0;
        rd_chk(ppr_pkg::OFS_CUT_CNT, 32'h4, "cut count");
        $display("test records done");
        wr(ppr_pkg::OFS_LD_ADDR, 32'h0);
        for (int i = 0; i < 256; i++)
        begin
            wr(ppr_pkg::OFS_PB_IN_LO, 32'h800 | 32'(i));
            wr(ppr_pkg::OFS_PB_IN_HI, 32'h0);
        end
        rd_chk(ppr_pkg::OFS_LD_ADDR, 32'h0, "load wrap");
        for (int i = 0; i < 256; i++)
        begin
            wr(ppr_pkg::OFS_PB_OUT_LO, 32'(i));
            wr(ppr_pkg::OFS_PB_OUT_HI, 32'h0000c300);
        end
        @(posedge core_clk);
        live_data <= LIVE_A;
        wr(ppr_pkg::OFS_CTRL, 32'he);
        repeat (3) @(posedge core_clk);
        #1 check(rt_out, {rec(2'h2, 12'h803), rec(2'h1, 12'hc02), rec(2'h0, 12'h801)}, "no playback");
        @(posedge core_clk);
        live_data <= '1;
        wr(ppr_pkg::OFS_CTRL, 32'hd);
        pb_watch(1'b0, 8'h02);
        wr(ppr_pkg::OFS_CTRL, 32'hf);
        pb_watch(1'b1, 8'h35);
        wr(ppr_pkg::OFS_CTRL, 32'hc);
        live_data <= '0;
        $display("test playback done");
        @(posedge core_clk);
        stall <= 1'b1;
        accept();
        accept();
        repeat (40) @(posedge core_clk);
        #1 check({47'h0, link_valid}, 48'h1, "stalled valid");
        @(posedge core_clk);
        stall <= 1'b0;
        wait_words(16'h8);
        check({32'h0, word_cnt}, 48'h8, "window words");
        check({32'h0, rec_cnt}, 48'h4, "record words");
        check({32'h0, hold_errs}, 48'h0, "stall hold");
        rd_chk(ppr_pkg::OFS_MISS_CNT, 32'h1, "accept in copy");
        wr(ppr_pkg::OFS_CTRL, 32'h4);
        accept();
        wait_words(16'hc);
        check({32'h0, word_cnt}, 48'hc, "one category");
        check({32'h0, rec_cnt}, 48'h4, "single kind");
        wr(ppr_pkg::OFS_CTRL, 32'h0);
        accept();
        repeat (40) @(posedge core_clk);
        #1 check({32'h0, word_cnt}, 48'hc, "none enabled");
        rd_chk(ppr_pkg::OFS_STATUS, 32'h0, "status idle");
        $display("test readout done");
        give_verdict();
    end
endmodule

`default_nettype wire
